// ==== logic/adc_link_if.sv ====
// Serial link between converter readout port and its master
`default_nettype none

interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic dout_o;
  logic dout_oe;
  logic dout_line;

  // Undriven output reads low on the wire
  assign dout_line = dout_oe & dout_o;

  modport device (
    input  sclk,
    input  cs_n,
    input  mosi,
    output dout_o,
    output dout_oe
  );

  modport master (
    output sclk,
    output cs_n,
    output mosi,
    input  dout_line
  );
endinterface

`default_nettype wire

// ==== logic/adc_link_pkg.sv ====
// Shared constants and types for the converter serial readout link
`default_nettype none

package adc_link_pkg;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam int CODE_BITS          = 14;
  localparam int SUB_BITS           = 2;
  localparam int RESULT_BITS        = CODE_BITS + SUB_BITS;
  localparam int BYTE_BITS          = 8;
  localparam int FRAME_BYTES        = 3;
  localparam int FRAME_BITS         = BYTE_BITS * FRAME_BYTES;
  localparam int LEAD_ZERO_BITS     = FRAME_BITS - RESULT_BITS;
  localparam int CONVERT_START_EDGE = 6;

  // ************************************************************
  // Master port configuration
  // ************************************************************
  localparam int         PORT_ENABLE_BIT         = 5;
  localparam int         CLOCK_IDLE_POLARITY_BIT = 4;
  localparam int         PORT_MODE_FIELD_MSB     = 3;
  localparam int         PORT_MODE_FIELD_LSB     = 0;
  localparam logic [3:0] PORT_MODE_DIV16         = 4'h1;
  localparam logic [7:0] MASTER_PORT_CONTROL     = 8'h21;
  localparam int         INPUT_SAMPLE_PHASE_BIT  = 7;
  localparam int         CLOCK_EDGE_SELECT_BIT   = 6;
  localparam logic [7:0] MASTER_PORT_STATE       = 8'h40;
  localparam int         MODE_DIVIDE             = 16;
  localparam logic [7:0] TX_FILL_BYTE            = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ       = 250;
  localparam int CS_GAP_NS     = 50;
  localparam int CS_GAP_CYCLES = (CS_GAP_NS * CLK_MHZ + 999) / 1000;

  // ************************************************************
  // Buffering and reset values
  // ************************************************************
  localparam int         FIFO_DEPTH     = 32;
  localparam logic [1:0] SYNC_HIGH_INIT = 2'h3;
  localparam logic [1:0] SYNC_LOW_INIT  = 2'h0;

  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,
    M_FRAME = 2'h1,
    M_PUSH  = 2'h3,
    M_GAP   = 2'h2
  } master_state_type;

endpackage

`default_nettype wire

// ==== logic/adc_readout_device.sv ====
// Converter end of the serial readout link
`default_nettype none

module adc_readout_device
  import adc_link_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  adc_link_if.device                link,
  input  wire logic [CODE_BITS-1:0] sample_code,
  input  wire logic [SUB_BITS-1:0]  sub_bits,
  output logic                      converting,
  output logic                      aborted,
  output logic                      shutdown
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0]           sclk_sync_q;
  logic [1:0]           cs_sync_q;
  logic                 sclk_prev_q;
  logic                 cs_prev_q;
  logic                 active_q;
  logic [4:0]           rise_cnt_q;
  logic [4:0]           fall_cnt_q;
  logic [CODE_BITS-1:0] code_q;
  logic [SUB_BITS-1:0]  sub_q;
  logic                 dout_q;
  logic                 dout_oe_q;
  logic                 converting_q;
  logic                 aborted_q;
  logic                 shutdown_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_sync_q <= SYNC_LOW_INIT;
      cs_sync_q   <= SYNC_HIGH_INIT;
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_sync_q <= {sclk_sync_q[0], link.sclk};
      cs_sync_q   <= {cs_sync_q[0], link.cs_n};
      sclk_prev_q <= sclk_sync_q[1];
      cs_prev_q   <= cs_sync_q[1];
    end
  end

  // ************************************************************
  // Edge decode
  // ************************************************************
  wire                  cs_high    = cs_sync_q[1];
  wire                  cs_fall    = cs_prev_q & ~cs_high;
  wire                  cs_rise    = ~cs_prev_q & cs_high;
  wire                  sclk_rise  = active_q & ~cs_high & ~sclk_prev_q & sclk_sync_q[1];
  wire                  sclk_fall  = active_q & ~cs_high & sclk_prev_q & ~sclk_sync_q[1];
  // Master may raise select on the 24th fall itself; that edge still ends the frame
  wire                  fell_raw   = active_q & sclk_prev_q & ~sclk_sync_q[1];
  wire                  sixth_rise = sclk_rise & (rise_cnt_q == 5'(CONVERT_START_EDGE - 1));
  wire [4:0]            next_fall  = fall_cnt_q + 5'h01;
  wire                  frame_done = next_fall == 5'(FRAME_BITS);
  wire                  last_fall  = fell_raw & frame_done;
  wire [FRAME_BITS-1:0] frame_w    = {{LEAD_ZERO_BITS{1'b0}}, code_q, sub_q};
  wire [4:0]            bit_index  = 5'(FRAME_BITS - 1) - next_fall;
  // Past the last sub-bit the index would wrap, so force zeros instead
  wire                  next_bit   = (next_fall < 5'(FRAME_BITS)) ? frame_w[bit_index] : 1'b0;

  // ************************************************************
  // Frame sequencing
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst || cs_high) begin
      // Chip select high clears all port state
      active_q   <= 1'b0;
      rise_cnt_q <= 5'h00;
      fall_cnt_q <= 5'h00;
      code_q     <= '0;
      sub_q      <= '0;
    end else if (cs_fall) begin
      active_q   <= 1'b1;
      rise_cnt_q <= 5'h00;
      fall_cnt_q <= 5'h00;
    end else begin
      if (sclk_rise && rise_cnt_q != 5'(CONVERT_START_EDGE)) begin
        rise_cnt_q <= rise_cnt_q + 5'h01;
      end
      if (sixth_rise) begin
        code_q <= sample_code;
        sub_q  <= sub_bits;
      end
      if (sclk_fall && fall_cnt_q != 5'(FRAME_BITS)) begin
        fall_cnt_q <= next_fall;
      end
    end
  end

  // ************************************************************
  // Output pin and status
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dout_q       <= 1'b0;
      dout_oe_q    <= 1'b0;
      converting_q <= 1'b0;
      aborted_q    <= 1'b0;
      shutdown_q   <= 1'b1;
    end else begin
      aborted_q  <= cs_rise & converting_q & ~last_fall;
      shutdown_q <= cs_high | (~active_q & ~cs_fall);
      if (cs_high) begin
        dout_q       <= 1'b0;
        dout_oe_q    <= 1'b0;
        converting_q <= 1'b0;
      end else if (cs_fall) begin
        dout_q    <= 1'b0;
        dout_oe_q <= 1'b1;
      end else begin
        if (sclk_fall) begin
          dout_q <= next_bit;
        end
        if (sixth_rise) begin
          converting_q <= 1'b1;
        end else if (sclk_fall && frame_done) begin
          converting_q <= 1'b0;
        end
      end
    end
  end

  assign link.dout_o  = dout_q;
  assign link.dout_oe = dout_oe_q;
  assign converting   = converting_q;
  assign aborted      = aborted_q;
  assign shutdown     = shutdown_q;

endmodule

`default_nettype wire

// ==== logic/adc_readout_master.sv ====
// Master end of the serial readout link with its result FIFO
`default_nettype none

module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  logic [WIDTH-1:0] head_q;
  logic             head_valid_q;
  wire  [PW-1:0]    rd_ptr_d    = rd_ptr_q + PW'(pop);
  wire  [PW:0]      count_d     = count_q + (PW+1)'(push) - (PW+1)'(pop);
  // Head is registered so the outputs leave straight from flops
  wire              head_bypass = push & (wr_ptr_q == rd_ptr_d);

  assign in_ready  = count_q != (PW+1)'(DEPTH);
  assign out_valid = head_valid_q;
  assign out_data  = head_q;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
    head_q <= head_bypass ? in_data : mem_q[rd_ptr_d];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      head_valid_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + PW'(1);
      end
      rd_ptr_q     <= rd_ptr_d;
      count_q      <= count_d;
      head_valid_q <= count_d != '0;
    end
  end
endmodule

module adc_readout_master
  import adc_link_pkg::*;
#(
  parameter int CLK_DIV = MODE_DIVIDE,
  parameter int DEPTH   = FIFO_DEPTH
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  adc_link_if.master                  link,
  input  wire logic                   start,
  output logic [RESULT_BITS-1:0]      result_data,
  output logic                        result_valid,
  input  wire logic                   result_ready,
  output logic                        busy
);

  // ************************************************************
  // Port configuration
  // ************************************************************
  localparam int HALF = CLK_DIV / 2;
  localparam logic [3:0] MODE_FIELD =
    MASTER_PORT_CONTROL[PORT_MODE_FIELD_MSB:PORT_MODE_FIELD_LSB];
  // Port enable bit is only checked below; the pins drive regardless of it
  localparam logic PORT_ON   = MASTER_PORT_CONTROL[PORT_ENABLE_BIT];
  localparam logic IDLE_LVL  = MASTER_PORT_CONTROL[CLOCK_IDLE_POLARITY_BIT];
  localparam logic LATE_SAMP = MASTER_PORT_STATE[INPUT_SAMPLE_PHASE_BIT];
  localparam logic TX_RISE   = MASTER_PORT_STATE[CLOCK_EDGE_SELECT_BIT];

  if (MODE_FIELD != PORT_MODE_DIV16 || CLK_DIV < MODE_DIVIDE || CLK_DIV > 512
      || (CLK_DIV % 2) != 0) begin : g_bad_div
    $error("Clock divider must be even, 16 to 512, with mode field 0001");
  end
  if (!PORT_ON || IDLE_LVL || LATE_SAMP || !TX_RISE) begin : g_bad_cfg
    $error("Master port configuration unsupported by the converter link");
  end

  // ************************************************************
  // State and pin synchroniser
  // ************************************************************
  master_state_type       state_q;
  logic [7:0]             div_cnt_q;
  logic [4:0]             fall_cnt_q;
  logic [2:0]             bit_cnt_q;
  logic [FRAME_BITS-1:0]  rx_q;
  logic [BYTE_BITS-1:0]   tx_q;
  logic [4:0]             gap_cnt_q;
  logic [1:0]             dout_sync_q;
  logic                   sclk_q;
  logic                   cs_n_q;
  logic                   mosi_q;
  logic                   busy_q;
  logic                   fifo_in_ready;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dout_sync_q <= SYNC_LOW_INIT;
    end else begin
      dout_sync_q <= {dout_sync_q[0], link.dout_line};
    end
  end

  // ************************************************************
  // Clock divider and edge decode
  // ************************************************************
  wire half_tick = div_cnt_q == 8'(HALF - 1);
  wire in_frame  = state_q == M_FRAME;
  wire rise_evt  = in_frame & half_tick & (sclk_q == IDLE_LVL);
  wire fall_evt  = in_frame & half_tick & (sclk_q != IDLE_LVL);
  wire last_fall = fall_evt & (fall_cnt_q == 5'(FRAME_BITS - 1));
  // Start only with room for the result, so the push never stalls
  wire start_ok  = (state_q == M_IDLE) & start & fifo_in_ready;
  wire gap_done  = gap_cnt_q == 5'(CS_GAP_CYCLES - 1);
  wire push      = state_q == M_PUSH;

  always_ff @(posedge ref_clk) begin
    if (rst || !in_frame || half_tick) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end

  // ************************************************************
  // Frame sequencer
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q    <= M_IDLE;
      cs_n_q     <= 1'b1;
      sclk_q     <= IDLE_LVL;
      fall_cnt_q <= 5'h00;
      gap_cnt_q  <= 5'h00;
      busy_q     <= 1'b0;
    end else begin
      case (state_q)
        M_IDLE: begin
          if (start_ok) begin
            state_q    <= M_FRAME;
            cs_n_q     <= 1'b0;
            fall_cnt_q <= 5'h00;
            busy_q     <= 1'b1;
          end
        end
        M_FRAME: begin
          if (half_tick) begin
            sclk_q <= ~sclk_q;
          end
          if (fall_evt) begin
            fall_cnt_q <= fall_cnt_q + 5'h01;
          end
          // Chip select stays low until all three bytes are in
          if (last_fall) begin
            state_q <= M_PUSH;
            cs_n_q  <= 1'b1;
          end
        end
        M_PUSH: begin
          state_q   <= M_GAP;
          gap_cnt_q <= 5'h00;
        end
        M_GAP: begin
          gap_cnt_q <= gap_cnt_q + 5'h01;
          if (gap_done) begin
            state_q <= M_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q <= M_IDLE;
          cs_n_q  <= 1'b1;
          sclk_q  <= IDLE_LVL;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Byte shifters
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst || start_ok) begin
      rx_q      <= '0;
      tx_q      <= TX_FILL_BYTE;
      bit_cnt_q <= 3'h0;
      mosi_q    <= 1'b0;
    end else if (rise_evt) begin
      // Synchronised line is several cycles old, well inside the half period
      rx_q      <= {rx_q[FRAME_BITS-2:0], dout_sync_q[1]};
      mosi_q    <= tx_q[BYTE_BITS-1];
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'(BYTE_BITS - 1)) begin
        tx_q <= TX_FILL_BYTE;
      end else begin
        tx_q <= {tx_q[BYTE_BITS-2:0], 1'b0};
      end
    end
  end

  // ************************************************************
  // Result buffer
  // ************************************************************
  result_fifo #(
    .WIDTH (RESULT_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_q[RESULT_BITS-1:0]),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;
  assign busy      = busy_q;

endmodule

`default_nettype wire

// ==== sim/adc_link_assertions.sv ====
// Concurrent checks on the serial readout link
`default_nettype none

module adc_link_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic dout_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Edge counters
  // ************************************************************
  logic       sclk_q;
  logic [5:0] fall_q;
  logic [5:0] rise_q;
  logic [3:0] edge_q;
  wire logic  fell_now;
  wire logic  rose_now;

  assign fell_now = sclk_q & ~sclk;
  assign rose_now = ~sclk_q & sclk;

  // Counts restart whenever the port is deselected
  always_ff @(posedge ref_clk) begin
    sclk_q <= sclk;
    fall_q <= (rst | cs_n) ? 6'h00 : fall_q + {5'h00, fell_now};
    rise_q <= (rst | cs_n) ? 6'h00 : rise_q + {5'h00, rose_now};
    edge_q <= (rst | cs_n | fell_now) ? 4'h0 : edge_q + {3'h0, edge_q != 4'hF};
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ************************************************************
  // Link rules
  // ************************************************************
  a_idle_low: assert property (cs_n |-> !sclk) else $error("clock moves while deselected");
  a_half_period: assert property ($changed(sclk) |=> $stable(sclk)[*7])
    else $error("clock half period short");
  a_dout_after_fall: assert property (dout_oe && $changed(dout_o) |-> edge_q <= 4'h6)
    else $error("data changed away from falling edge");
  a_tx_on_rise: assert property ($changed(mosi) |-> rose_now)
    else $error("master data changed off rising edge");
  a_lead_zeros: assert property (rose_now && !cs_n && rise_q < 6'h08 |-> !dout_line)
    else $error("lead byte not zero");
  a_first_rise: assert property ($fell(cs_n) |-> !sclk[*6] ##[1:4] $rose(sclk))
    else $error("first clock misplaced after select");
  a_oe_start: assert property ($fell(cs_n) |-> ##[1:6] (dout_oe && !dout_line))
    else $error("output not driven low after select");
  a_frame_falls: assert property ($rose(cs_n) |-> fall_q + {5'h00, fell_now} == 6'h18)
    else $error("select released inside frame");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] !dout_oe)
    else $error("output still driven after release");
  a_cs_gap: assert property ($rose(cs_n) |=> cs_n[*8])
    else $error("select gap too short");
endmodule

`default_nettype wire

// ==== sim/tb_top.sv ====
// Testbench for both ends of the readout link
`default_nettype none

module tb_top;
  import adc_link_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   ref_clk;
  logic                   rst;
  logic                   start;
  logic                   result_ready;
  logic [CODE_BITS-1:0]   sample_code;
  logic [SUB_BITS-1:0]    sub_bits;
  logic [RESULT_BITS-1:0] result_data;
  logic                   result_valid;
  logic                   busy;
  logic                   converting;
  logic                   aborted;
  logic                   shutdown;
  logic                   conv2;
  logic                   abort2;
  logic                   shut2;
  logic                   hit;
  logic                   abort_seen;
  logic [23:0]            wire_q;
  logic [23:0]            cap2;
  int                     failures;
  int                     num_checks;
  logic [13:0]            codes [4] = '{14'h0000, 14'h3FFF, 14'h2A5C, 14'h1234};
  logic [1:0]             subs [4]  = '{2'h0, 2'h3, 2'h2, 2'h1};

  adc_link_if link ();
  adc_link_if link2 ();

  adc_readout_master adc_readout_master_i (.ref_clk(ref_clk), .rst(rst), .link(link),
    .start(start), .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready), .busy(busy));
  adc_readout_device adc_readout_device_i (.ref_clk(ref_clk), .rst(rst), .link(link),
    .sample_code(sample_code), .sub_bits(sub_bits), .converting(converting),
    .aborted(aborted), .shutdown(shutdown));
  // Second converter driven by the bench to break the master's rules
  adc_readout_device adc_readout_device_i2 (.ref_clk(ref_clk), .rst(rst), .link(link2),
    .sample_code(sample_code), .sub_bits(sub_bits), .converting(conv2),
    .aborted(abort2), .shutdown(shut2));
  adc_link_assertions adc_link_assertions_i (.ref_clk(ref_clk), .rst(rst),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .dout_o(link.dout_o),
    .dout_oe(link.dout_oe), .dout_line(link.dout_line));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Wire capture on rising clock, as the master would
  always @(posedge link.sclk) begin
    if (link.cs_n === 1'b0) wire_q <= {wire_q[22:0], link.dout_line};
  end

  // A clean end of frame must never be reported as an abort
  always @(posedge ref_clk) begin
    if (rst) begin
      abort_seen <= 1'b0;
    end else if (aborted) begin
      abort_seen <= 1'b1;
    end
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic readout(input logic [13:0] c, input logic [1:0] s);
    int n;
    sample_code = c;
    sub_bits = s;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 2000) begin
      check("readout timeout", 24'h0, 24'h1);
      complete_run();
    end
  endtask

  task automatic pop(input logic [15:0] e);
    check("valid", 24'h1, {23'h0, result_valid});
    check("result", {8'h00, e}, {8'h00, result_data});
    result_ready = 1'b1;
    @(negedge ref_clk);
    result_ready = 1'b0;
    @(negedge ref_clk);
  endtask

  // Half period of eight cycles, the same as the master's
  task automatic tick2(input int n);
    repeat (n) begin
      link2.sclk = 1'b1;
      cap2 = {cap2[22:0], link2.dout_line};
      repeat (8) @(negedge ref_clk);
      link2.sclk = 1'b0;
      repeat (8) @(negedge ref_clk);
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    failures = 0;
    num_checks = 0;
    rst = 1'b1;
    start = 1'b0;
    result_ready = 1'b0;
    sample_code = 14'h0000;
    sub_bits = 2'h0;
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.mosi = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      readout(codes[i], subs[i]);
      check("lead byte", 24'h0, {16'h0, wire_q[23:16]});
      check("high byte", {16'h0, codes[i][13:6]}, {16'h0, wire_q[15:8]});
      check("low byte", {16'h0, codes[i][5:0], subs[i]}, {16'h0, wire_q[7:0]});
      check("shutdown", 24'h1, {23'h0, shutdown});
      check("idle converting", 24'h0, {23'h0, converting});
      check("false abort", 24'h0, {23'h0, abort_seen});
      pop({codes[i], subs[i]});
    end
    // Fill the result store while nothing is read
    for (int i = 0; i < FIFO_DEPTH; i++) readout(14'(i) * 14'h0203, 2'(i));
    start = 1'b1;
    repeat (3) @(negedge ref_clk);
    start = 1'b0;
    check("busy when full", 24'h0, {23'h0, busy});
    for (int i = 0; i < FIFO_DEPTH; i++) pop({14'(i) * 14'h0203, 2'(i)});
    check("empty", 24'h0, {23'h0, result_valid});
    check("false abort", 24'h0, {23'h0, abort_seen});
    // Abort in mid-conversion on the second link
    link2.cs_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    tick2(10);
    check("converting", 24'h1, {23'h0, conv2});
    link2.cs_n = 1'b1;
    hit = 1'b0;
    repeat (8) begin
      @(negedge ref_clk);
      hit = hit | abort2;
    end
    check("aborted", 24'h1, {23'h0, hit});
    check("abort shutdown", 24'h1, {23'h0, shut2});
    repeat (16) @(negedge ref_clk);
    // Full frame followed by eight surplus clocks
    sample_code = 14'h2DB6;
    sub_bits = 2'h1;
    link2.cs_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    tick2(32);
    check("trailing zeros", {14'h2DB6, 2'h1, 8'h00}, cap2);
    check("finished", 24'h0, {23'h0, conv2});
    link2.cs_n = 1'b1;
    repeat (16) @(negedge ref_clk);
    check("idle shutdown", 24'h1, {23'h0, shut2});
    complete_run();
  end
endmodule

`default_nettype wire
